// ==== pkg/dbi_defines.svh ====
// Purpose: Constants for the drive bus idle interrupt state machine
// Assumes: 40 MHz clock, 25 ns period
// Notes:   Times kept in their own units, cycle counts derived here
`ifndef DBI_DEFINES_SVH
`define DBI_DEFINES_SVH
`define DBI_CLK_PERIOD_NS     25
`define DBI_INTRQ_MAX_NS      400
`define DBI_INTRQ_CYC         (`DBI_INTRQ_MAX_NS / `DBI_CLK_PERIOD_NS)
`define DBI_READY_MAX_S       30
`define DBI_DIAG_MAX_S        31
`define DBI_CLK_HZ            40000000
`define DBI_READY_CYC         (`DBI_READY_MAX_S * `DBI_CLK_HZ)
`define DBI_DIAG_CYC          (`DBI_DIAG_MAX_S * `DBI_CLK_HZ)
`define DBI_CNT_W             32
`define DBI_TAG_W             5
`define DBI_CMD_W             8
`define DBI_CMD_SERVICE       8'hA2
`endif

// ==== pkg/dbi_pkg.sv ====
// Purpose: Types for the drive bus idle interrupt state machine
// Assumes: dbi_defines.svh supplies widths
// Notes:   One-hot state codes
`include "dbi_defines.svh"
package dbi_pkg;
  typedef enum logic [8:0] {
    DBI_SEL_INT   = 9'h001,
    DBI_SEL_QUIET = 9'h002,
    DBI_NOT_SEL   = 9'h004,
    DBI_REL_INT   = 9'h008,
    DBI_REL_QUIET = 9'h010,
    DBI_SRV_INT   = 9'h020,
    DBI_SRV_QUIET = 9'h040,
    DBI_REL_NSEL  = 9'h080,
    DBI_BUSY      = 9'h100
  } dbi_state_t;

  typedef struct packed {
    logic                  status_rd;
    logic                  other_rd;
    logic                  cmd_wr;
    logic                  dev_wr;
    logic                  other_wr;
    logic                  drive_select_bit;
    logic                  interrupt_disable_bit;
    logic [`DBI_CMD_W-1:0] cmd;
  } dbi_host_t;

  typedef struct packed {
    logic                  cmd_done;
    logic                  cmd_released;
    logic                  release_flag;
    logic                  service_flag;
    logic                  ready_to_continue;
    logic                  queued_cmd;
    logic [`DBI_TAG_W-1:0] service_tag;
  } dbi_core_t;
endpackage : dbi_pkg

// ==== core/dbi_strobe_sync.sv ====
// Purpose: Two-flop synchroniser and negation pulse for a host strobe
// Assumes: Strobe active low from the pins
// Notes:   Pulse marks strobe negation
`timescale 1ns/1ps
module dbi_strobe_sync
  import dbi_pkg::*;
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic strobe_n,
  output logic      negate_pulse
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= strobe_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign negate_pulse = s2_r & ~s3_r;
endmodule : dbi_strobe_sync

// ==== core/dbi_timer.sv ====
// Purpose: Post-reset deadline counter
// Assumes: Starts on release of reset
// Notes:   Done is a level once the limit is reached
`timescale 1ns/1ps
`include "dbi_defines.svh"
module dbi_timer
  import dbi_pkg::*;
#(
  parameter logic [`DBI_CNT_W-1:0] LIMIT = 32'h0000_0010
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic restart,
  output logic      done
);
  logic [`DBI_CNT_W-1:0] cnt_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (restart) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done = (cnt_r == LIMIT);
endmodule : dbi_timer

// ==== core/dbi_idle_fsm.sv ====
// Purpose: Device bus idle state machine with interrupt handling
// Assumes: Register decode is done outside; strobes arrive as pins
// Notes:   Decisions taken on strobe negation
//
// Functional notes
// - Selected interrupting idle: busy, request zero, INTRQ on; other reads ignored.
// - Command write there clears pending, drops INTRQ, releases diag pins.
// - Status read there clears pending, drops INTRQ, goes quiet idle.
// - Setting interrupt disable there drops INTRQ and goes quiet idle.
// - Non-command writes and self-select writes keep interrupting idle.
// - Selecting the other device releases INTRQ and goes not-selected.
// - Quiet idle: flags zero, INTRQ off; device 0 enters after reset.
// - Without packet set, ready flag set within 30 s of reset.
// - Command write in quiet idle clears pending, releases diag, starts command.
// - Quiet idle keeps on other writes; selecting other device deselects.
// - Not-selected idle: flags zero, INTRQ released; device 1 after reset.
// - Without packet set, not-selected device releases diag pins within 31 s.
// - Reselection goes interrupting if pending and enabled, else quiet.
// - Released with pending, enabled, release set, service clear: released interrupting.
// - Non-queued command with queue present aborts queue and command; code pulses queue_abort_r and still starts the command.
// - Status read or command write in released interrupting clears pending.
// - Ready to continue from released interrupting goes service interrupting.
// - Released quiet: flags zero, INTRQ off; command starts, deselect moves.
// - Ready from released quiet: service interrupting if enabled, else quiet.
// - Service command loads tag, drops INTRQ, resumes the command.
`timescale 1ns/1ps
`include "dbi_defines.svh"
module dbi_idle_fsm
  import dbi_pkg::*;
#(
  parameter logic [`DBI_CNT_W-1:0] READY_CYCLES = `DBI_READY_CYC,
  parameter logic [`DBI_CNT_W-1:0] DIAG_CYCLES  = `DBI_DIAG_CYC
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  dior_n,
  input  wire logic                  diow_n,
  input  wire dbi_host_t             host,
  input  wire dbi_core_t             core,
  input  wire logic                  soft_reset,
  input  wire logic                  is_device1,
  input  wire logic                  packet_set,
  output logic                       intrq_r,
  output logic                       intrq_oen_r,
  output logic                       busy_flag_r,
  output logic                       data_request_flag_r,
  output logic                       ready_flag_r,
  output logic                       diag_oen_r,
  output logic                       dasp_oen_r,
  output logic                       cmd_start_r,
  output logic [`DBI_CMD_W-1:0]      cmd_code_r,
  output logic                       queue_abort_r,
  output logic                       service_resume_r,
  output logic [`DBI_TAG_W-1:0]      tag_r,
  output logic [8:0]                 state_r
);
  dbi_state_t st_r;
  dbi_state_t st_nxt;
  logic       pend_r;
  logic       rd_neg;
  logic       wr_neg;
  logic       rst_entry_r;
  logic       ready_done;
  logic       diag_done;
  logic       sel_bit_me;
  logic       rd_stat;
  logic       wr_cmd;
  logic       wr_dev;
  logic       wr_other;
  logic       en;
  logic       is_service;
  logic       idle_sel;
  logic       dis_s1_r;
  logic       dis_s2_r;

  dbi_strobe_sync u_rd (
    .clock        (clock),
    .rstn         (rstn),
    .strobe_n     (dior_n),
    .negate_pulse (rd_neg)
  );

  dbi_strobe_sync u_wr (
    .clock        (clock),
    .rstn         (rstn),
    .strobe_n     (diow_n),
    .negate_pulse (wr_neg)
  );

  dbi_timer #(.LIMIT(READY_CYCLES)) u_ready (
    .clock   (clock),
    .rstn    (rstn),
    .restart (soft_reset),
    .done    (ready_done)
  );

  dbi_timer #(.LIMIT(DIAG_CYCLES)) u_diag (
    .clock   (clock),
    .rstn    (rstn),
    .restart (soft_reset),
    .done    (diag_done)
  );

  assign sel_bit_me = (host.drive_select_bit == is_device1);
  assign rd_stat    = rd_neg & host.status_rd;
  assign wr_cmd     = wr_neg & host.cmd_wr;
  assign wr_dev     = wr_neg & host.dev_wr;
  assign wr_other   = wr_neg & host.other_wr;
  assign en         = ~dis_s2_r;
  assign is_service = (host.cmd == `DBI_CMD_SERVICE);
  assign idle_sel   = (st_r == DBI_SEL_INT) | (st_r == DBI_SEL_QUIET);

  // Interrupt disable bit passes two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dis_s1_r <= 1'b0;
      dis_s2_r <= 1'b0;
    end else begin
      dis_s1_r <= host.interrupt_disable_bit;
      dis_s2_r <= dis_s1_r;
    end
  end

  // Next state; reads other than Status are not decoded at all
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DBI_SEL_INT: begin
        if (wr_cmd)                          st_nxt = DBI_BUSY;
        else if (rd_stat || !en)             st_nxt = DBI_SEL_QUIET;
        else if (wr_dev && !sel_bit_me)      st_nxt = DBI_NOT_SEL;
        else if (wr_other)                   st_nxt = DBI_SEL_INT;
        else                                 st_nxt = DBI_SEL_INT;
      end
      DBI_SEL_QUIET: begin
        if (wr_cmd)                          st_nxt = DBI_BUSY;
        else if (wr_dev && !sel_bit_me)      st_nxt = DBI_NOT_SEL;
        else if (wr_other)                   st_nxt = DBI_SEL_QUIET;
      end
      DBI_NOT_SEL: begin
        if (wr_dev && sel_bit_me)
          st_nxt = (pend_r && en) ? DBI_SEL_INT : DBI_SEL_QUIET;
      end
      DBI_REL_INT: begin
        if (wr_cmd)                          st_nxt = DBI_BUSY;
        else if (rd_stat)                    st_nxt = DBI_REL_QUIET;
        else if (wr_dev && !sel_bit_me)      st_nxt = DBI_REL_NSEL;
        else if (core.ready_to_continue)     st_nxt = DBI_SRV_INT;
      end
      DBI_REL_QUIET: begin
        if (wr_cmd)                          st_nxt = DBI_BUSY;
        else if (wr_dev && !sel_bit_me)      st_nxt = DBI_REL_NSEL;
        else if (core.ready_to_continue)
          st_nxt = en ? DBI_SRV_INT : DBI_SRV_QUIET;
      end
      DBI_SRV_INT: begin
        if (wr_cmd)                          st_nxt = DBI_BUSY;
        else if (rd_stat)                    st_nxt = DBI_SRV_QUIET;
        else if (wr_dev && !sel_bit_me)      st_nxt = DBI_REL_NSEL;
      end
      DBI_SRV_QUIET: begin
        if (wr_cmd)                          st_nxt = DBI_BUSY;
        else if (wr_dev && !sel_bit_me)      st_nxt = DBI_REL_NSEL;
      end
      DBI_REL_NSEL: begin
        if (wr_dev && sel_bit_me) begin
          if (core.service_flag)
            st_nxt = (pend_r && en) ? DBI_SRV_INT : DBI_SRV_QUIET;
          else
            st_nxt = (pend_r && en) ? DBI_REL_INT : DBI_REL_QUIET;
        end
      end
      DBI_BUSY: begin
        if (core.cmd_done || core.cmd_released) begin
          if (core.release_flag && core.service_flag)
            st_nxt = en ? DBI_SRV_INT : DBI_SRV_QUIET;
          else if (core.release_flag)
            st_nxt = en ? DBI_REL_INT : DBI_REL_QUIET;
          else
            st_nxt = en ? DBI_SEL_INT : DBI_SEL_QUIET;
        end
      end
      default: st_nxt = DBI_SEL_QUIET;
    endcase
    // Reset entry depends on device number
    if (soft_reset || rst_entry_r) begin
      st_nxt = is_device1 ? DBI_NOT_SEL : DBI_SEL_QUIET;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= DBI_SEL_QUIET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_entry_r <= 1'b1;
    end else begin
      rst_entry_r <= 1'b0;
    end
  end

  // Pending bit; a completion in the clear cycle wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
    end else if (core.cmd_done || core.cmd_released || core.ready_to_continue) begin
      pend_r <= 1'b1;
    end else if (soft_reset || wr_cmd || rd_stat) begin
      pend_r <= 1'b0;
    end
  end

  // INTRQ: asserted in interrupting states only, within one sync delay
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      intrq_r     <= 1'b0;
      intrq_oen_r <= 1'b1;
    end else begin
      intrq_r     <= ((st_nxt == DBI_SEL_INT) || (st_nxt == DBI_REL_INT) ||
                      (st_nxt == DBI_SRV_INT)) && en;
      intrq_oen_r <= (st_nxt == DBI_NOT_SEL) || (st_nxt == DBI_REL_NSEL);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_flag_r         <= 1'b0;
      data_request_flag_r <= 1'b0;
    end else begin
      busy_flag_r         <= (st_nxt == DBI_BUSY);
      data_request_flag_r <= 1'b0;
    end
  end

  // Ready flag after reset in plain idle, never for packet devices
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ready_flag_r <= 1'b0;
    end else if (soft_reset) begin
      ready_flag_r <= 1'b0;
    end else if (!packet_set && ready_done) begin
      ready_flag_r <= 1'b1;
    end
  end

  // Diagnostic pins released on command or after deadline
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      diag_oen_r <= 1'b0;
      dasp_oen_r <= 1'b0;
    end else if (soft_reset) begin
      diag_oen_r <= 1'b0;
      dasp_oen_r <= 1'b0;
    end else begin
      if (wr_cmd && idle_sel)
        diag_oen_r <= 1'b1;
      if (wr_cmd && (st_r == DBI_SEL_INT))
        dasp_oen_r <= 1'b1;
      if (!packet_set && diag_done && (st_r == DBI_NOT_SEL)) begin
        diag_oen_r <= 1'b1;
        dasp_oen_r <= 1'b1;
      end
    end
  end

  // Command hand-off, queue abort and service tag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_start_r      <= 1'b0;
      cmd_code_r       <= '0;
      queue_abort_r    <= 1'b0;
      service_resume_r <= 1'b0;
      tag_r            <= '0;
    end else begin
      cmd_start_r      <= wr_cmd && (st_nxt == DBI_BUSY) && !is_service;
      queue_abort_r    <= 1'b0;
      service_resume_r <= 1'b0;
      if (wr_cmd)
        cmd_code_r <= host.cmd;
      if (wr_cmd && core.release_flag && !core.queued_cmd && !is_service)
        queue_abort_r <= 1'b1;
      if (wr_cmd && is_service &&
          ((st_r == DBI_SRV_INT) || (st_r == DBI_SRV_QUIET))) begin
        tag_r            <= core.service_tag;
        service_resume_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= DBI_SEL_QUIET;
    end else begin
      state_r <= st_nxt;
    end
  end
endmodule : dbi_idle_fsm

// ==== sim/dbi_idle_fsm_sva.sv ====
// Purpose: Port-level checks of the bus idle state machine
// Assumes: Answers within 16 cycles of strobe negation
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
module dbi_idle_fsm_sva
  import dbi_pkg::*;
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       dior_n,
  input wire logic       diow_n,
  input wire dbi_host_t  host,
  input wire logic       is_device1,
  input wire logic       packet_set,
  input wire logic       intrq_r,
  input wire logic       intrq_oen_r,
  input wire logic       busy_flag_r,
  input wire logic       data_request_flag_r,
  input wire logic       ready_flag_r,
  input wire logic       cmd_start_r,
  input wire logic [8:0] state_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_sel_int_flags: assert property (
    state_r == DBI_SEL_INT |-> !busy_flag_r && !data_request_flag_r)
    else $error("busy or request in selected interrupting idle");
  a_quiet_flags: assert property (
    state_r == DBI_SEL_QUIET |-> !busy_flag_r && !data_request_flag_r && !intrq_r)
    else $error("quiet idle flags wrong");
  a_nsel_release: assert property (
    (state_r == DBI_NOT_SEL || state_r == DBI_REL_NSEL) |-> intrq_oen_r && !busy_flag_r)
    else $error("not selected device drives interrupt");
  a_status_clear: assert property (
    $rose(dior_n) && host.status_rd && state_r == DBI_SEL_INT
      |-> ##[1:16] (state_r == DBI_SEL_QUIET && !intrq_r))
    else $error("status read did not clear interrupt");
  a_cmd_clear: assert property (
    $rose(diow_n) && host.cmd_wr && state_r == DBI_SEL_INT |-> ##[1:16] (cmd_start_r && !intrq_r))
    else $error("command write did not start or clear");
  a_deselect_drop: assert property (
    $rose(diow_n) && host.dev_wr && host.drive_select_bit != is_device1
      && state_r == DBI_SEL_INT |-> ##[1:16] (state_r == DBI_NOT_SEL && intrq_oen_r))
    else $error("deselect did not release interrupt");
  a_disable_drop: assert property (
    state_r == DBI_SEL_INT && host.interrupt_disable_bit
      |-> ##[1:16] (state_r == DBI_SEL_QUIET && !intrq_r))
    else $error("interrupt disable ignored");
  a_reselect_idle: assert property (
    $rose(diow_n) && host.dev_wr && host.drive_select_bit == is_device1
      && state_r == DBI_NOT_SEL |-> ##[1:16] (state_r inside {DBI_SEL_INT, DBI_SEL_QUIET}))
    else $error("reselect did not reach selected idle");
  a_intrq_scope: assert property (
    intrq_r |-> state_r inside {DBI_SEL_INT, DBI_REL_INT, DBI_SRV_INT})
    else $error("interrupt asserted outside interrupting state");
  a_ready_packet: assert property (
    packet_set |-> !ready_flag_r)
    else $error("ready set with packet feature");
endmodule : dbi_idle_fsm_sva

// ==== sim/dbi_host_model.sv ====
// Purpose: Host controller model driving strobes and register decode
// Assumes: Strobe low 3 cycles, decode held 5 cycles after negation
// Notes:   Command lines show inverse data once released
`timescale 1ns/1ps
`include "dbi_defines.svh"
module dbi_host_model
  import dbi_pkg::*;
(
  input wire logic clock,
  output logic     dior_n,
  output logic     diow_n,
  output dbi_host_t host
);
  initial begin
    dior_n = 1'b1;
    diow_n = 1'b1;
    host = '0;
  end
  // Kind 0 status rd, 1 other rd, 2 command wr, 3 select wr, 4 other wr
  task automatic access(input logic [2:0] kind, input logic dsb,
                        input logic [`DBI_CMD_W-1:0] c);
    @(negedge clock);
    {host.status_rd, host.other_rd, host.cmd_wr, host.dev_wr, host.other_wr} = 5'h10 >> kind;
    if (kind == 3'h3) host.drive_select_bit = dsb;
    host.cmd = c;
    if (kind < 3'h2) dior_n = 1'b0;
    else diow_n = 1'b0;
    repeat (3) @(negedge clock);
    dior_n = 1'b1;
    diow_n = 1'b1;
    repeat (5) @(negedge clock);
    {host.status_rd, host.other_rd, host.cmd_wr, host.dev_wr, host.other_wr} = 5'h00;
    host.cmd = ~c;
  endtask : access
  task automatic set_interrupt_disable_bit(input logic v);
    @(negedge clock);
    host.interrupt_disable_bit = v;
    repeat (3) @(negedge clock);
  endtask : set_interrupt_disable_bit
endmodule : dbi_host_model

// ==== sim/tb_drive_bus_idle_interrupt_fsm.sv ====
// Purpose: Self-checking bench of the bus idle state machine
// Assumes: Short ready and diagnostic limits of 16 and 20 cycles
// Notes:   Starts, tags and aborts checked from queues
`timescale 1ns/1ps
`include "dbi_defines.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, (e), (g)); end end
module tb_drive_bus_idle_interrupt_fsm;
  import dbi_pkg::*;
  logic clock, rstn, soft_reset, is_device1, packet_set, dior_n, diow_n;
  dbi_host_t host;
  dbi_core_t core;
  logic intrq_r, intrq_oen_r, busy_flag_r, data_request_flag_r, ready_flag_r;
  logic diag_oen_r, dasp_oen_r, cmd_start_r, queue_abort_r, service_resume_r;
  logic [7:0] cmd_code_r;
  logic [4:0] tag_r;
  logic [8:0] state_r;
  logic [7:0] exp_cmd_q[$];
  logic [4:0] exp_tag_q[$];
  logic exp_ab_q[$];
  logic [7:0] exp_c;
  logic [4:0] exp_t;
  logic exp_a;
  logic [15:0] lfsr_q = 16'h5E1D;
  int mismatches = 0;
  int n_checks = 0;
  dbi_host_model u_host (.clock(clock), .dior_n(dior_n), .diow_n(diow_n), .host(host));
  dbi_idle_fsm #(.READY_CYCLES(32'h0000_0010), .DIAG_CYCLES(32'h0000_0014)) u_dut (
    .clock(clock), .rstn(rstn), .dior_n(dior_n), .diow_n(diow_n), .host(host),
    .core(core), .soft_reset(soft_reset), .is_device1(is_device1),
    .packet_set(packet_set), .intrq_r(intrq_r), .intrq_oen_r(intrq_oen_r),
    .busy_flag_r(busy_flag_r), .data_request_flag_r(data_request_flag_r),
    .ready_flag_r(ready_flag_r), .diag_oen_r(diag_oen_r), .dasp_oen_r(dasp_oen_r),
    .cmd_start_r(cmd_start_r), .cmd_code_r(cmd_code_r), .queue_abort_r(queue_abort_r),
    .service_resume_r(service_resume_r), .tag_r(tag_r), .state_r(state_r));
  always #12.5 clock = ~clock;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic pulse(input logic [2:0] p);
    @(negedge clock);
    {core.cmd_done, core.cmd_released, core.ready_to_continue} = p;
    @(negedge clock);
    {core.cmd_done, core.cmd_released, core.ready_to_continue} = 3'h0;
  endtask : pulse
  task automatic see(input logic [8:0] s, input logic irq);
    repeat (8) @(negedge clock);
    `CHK("state", s, state_r)
    `CHK("intrq", irq, intrq_r)
  endtask : see
  task automatic cmd_wr(input logic start);
    logic [7:0] c;
    lfsr_q = lfsr_next(lfsr_q);
    c = (lfsr_q[7:0] == `DBI_CMD_SERVICE) ? 8'h20 : lfsr_q[7:0];
    if (start) exp_cmd_q.push_back(c);
    u_host.access(3'h2, 1'b0, c);
  endtask : cmd_wr
  task automatic srv();
    lfsr_q = lfsr_next(lfsr_q);
    core.service_tag = lfsr_q[4:0];
    exp_tag_q.push_back(lfsr_q[4:0]);
    u_host.access(3'h2, 1'b0, `DBI_CMD_SERVICE);
    core.service_flag = 1'b0;
  endtask : srv
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(negedge clock) begin
    if (cmd_start_r) begin
      exp_c = (exp_cmd_q.size() > 0) ? exp_cmd_q.pop_front() : ~cmd_code_r;
      `CHK("cmd_code", exp_c, cmd_code_r)
    end
    if (service_resume_r) begin
      exp_t = (exp_tag_q.size() > 0) ? exp_tag_q.pop_front() : ~tag_r;
      `CHK("tag", exp_t, tag_r)
    end
    if (queue_abort_r) begin
      exp_a = (exp_ab_q.size() > 0) ? exp_ab_q.pop_front() : 1'b0;
      `CHK("abort", exp_a, 1'b1)
    end
  end
  initial begin
    #(25 * 4000);
    mismatches++;
    finish_test();
  end
  initial begin
    logic [2:0] kl[3] = '{3'h1, 3'h3, 3'h4};
    clock = 0; rstn = 0; soft_reset = 0; is_device1 = 0; packet_set = 0; core = '0;
    repeat (2) @(negedge clock);
    rstn = 1;
    see(DBI_SEL_QUIET, 1'b0);
    repeat (10) @(negedge clock);
    `CHK("ready", 1'b1, ready_flag_r)
    cmd_wr(1'b1);
    pulse(3'h4);
    see(DBI_SEL_INT, 1'b1);
    foreach (kl[i]) begin
      u_host.access(kl[i], 1'b0, 8'h00); see(DBI_SEL_INT, 1'b1);
    end
    u_host.access(3'h0, 1'b0, 8'h00); see(DBI_SEL_QUIET, 1'b0);
    u_host.access(3'h3, 1'b1, 8'h00); see(DBI_NOT_SEL, 1'b0);
    `CHK("intrq_oen", 1'b1, intrq_oen_r)
    u_host.access(3'h3, 1'b0, 8'h00); see(DBI_SEL_QUIET, 1'b0);
    cmd_wr(1'b1); pulse(3'h4); see(DBI_SEL_INT, 1'b1);
    `CHK("diag_oen", 1'b1, diag_oen_r)
    u_host.access(3'h3, 1'b1, 8'h00); see(DBI_NOT_SEL, 1'b0);
    u_host.access(3'h3, 1'b0, 8'h00); see(DBI_SEL_INT, 1'b1);
    cmd_wr(1'b1); pulse(3'h4);
    `CHK("dasp_oen", 1'b1, dasp_oen_r)
    u_host.set_interrupt_disable_bit(1'b1); see(DBI_SEL_QUIET, 1'b0);
    $display("test selected idle finished");
    u_host.set_interrupt_disable_bit(1'b0);
    cmd_wr(1'b1);
    core.release_flag = 1'b1;
    pulse(3'h2); see(DBI_REL_INT, 1'b1);
    u_host.set_interrupt_disable_bit(1'b1);
    u_host.access(3'h0, 1'b0, 8'h00); see(DBI_REL_QUIET, 1'b0);
    core.service_flag = 1'b1;
    pulse(3'h1); see(DBI_SRV_QUIET, 1'b0);
    srv();
    u_host.set_interrupt_disable_bit(1'b0);
    pulse(3'h2); see(DBI_REL_INT, 1'b1);
    core.service_flag = 1'b1;
    pulse(3'h1); see(DBI_SRV_INT, 1'b1);
    srv();
    `CHK("intrq", 1'b0, intrq_r)
    pulse(3'h2); core.queued_cmd = 1'b1; cmd_wr(1'b1);
    `CHK("intrq", 1'b0, intrq_r)
    pulse(3'h2); u_host.access(3'h0, 1'b0, 8'h00); see(DBI_REL_QUIET, 1'b0);
    u_host.access(3'h3, 1'b1, 8'h00); see(DBI_REL_NSEL, 1'b0);
    u_host.access(3'h3, 1'b0, 8'h00); see(DBI_REL_QUIET, 1'b0);
    core.queued_cmd = 1'b0; exp_ab_q.push_back(1'b1); cmd_wr(1'b1);
    repeat (4) @(negedge clock);
    $display("test released idle finished");
    core = '0;
    soft_reset = 1'b1; @(negedge clock); soft_reset = 1'b0;
    see(DBI_SEL_QUIET, 1'b0);
    rstn = 0; is_device1 = 1; @(negedge clock); rstn = 1;
    see(DBI_NOT_SEL, 1'b0);
    repeat (20) @(negedge clock);
    `CHK("diag_dasp", 2'b11, {diag_oen_r, dasp_oen_r})
    `CHK("ready", 1'b1, ready_flag_r)
    rstn = 0; is_device1 = 0; packet_set = 1; @(negedge clock); rstn = 1;
    repeat (30) @(negedge clock);
    `CHK("ready", 1'b0, ready_flag_r)
    `CHK("notes_left", 0, exp_cmd_q.size() + exp_tag_q.size() + exp_ab_q.size())
    $display("test resets finished");
    finish_test();
  end
endmodule : tb_drive_bus_idle_interrupt_fsm
bind dbi_idle_fsm dbi_idle_fsm_sva u_sva (
  .clock(clock), .rstn(rstn), .dior_n(dior_n), .diow_n(diow_n), .host(host),
  .is_device1(is_device1), .packet_set(packet_set), .intrq_r(intrq_r),
  .intrq_oen_r(intrq_oen_r), .busy_flag_r(busy_flag_r),
  .data_request_flag_r(data_request_flag_r), .ready_flag_r(ready_flag_r),
  .cmd_start_r(cmd_start_r), .state_r(state_r));
